// ===== irq_flags_regs.svh
// Purpose: Register offsets, field positions and reset values of the interrupt flag block
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address, one aligned word per register
// Notes:   Registers sit in the low half of the word, 16 bits wide except the 3-bit status and mask; upper half reads zero
`ifndef IRQ_FLAGS_REGS_SVH
`define IRQ_FLAGS_REGS_SVH

`define IFR_ADDR_W          8
`define IFR_CTRL_OFS        8'h00
`define IFR_FLAGS0_OFS      8'h04
`define IFR_FLAGS1_OFS      8'h08
`define IFR_FLAGS2_OFS      8'h0c
`define IFR_IRQ_STATUS_OFS  8'h10
`define IFR_IRQ_MASK_OFS    8'h14

`define IFR_CTRL_ALT_BIT    15
`define IFR_CTRL_DIS_BIT    14
`define IFR_CTRL_POL_MSB    4
`define IFR_EXT_COUNT       5

`define IFR_FLAGS0_IMPL     16'h7fff
`define IFR_FLAGS1_IMPL     16'hfffb
`define IFR_FLAGS2_IMPL     16'hdfff

`define IFR_EXT0_BIT        0
`define IFR_EXT1_BIT        4
`define IFR_EXT2_BIT        13

`define IFR_IRQ_W           3
`define IFR_REG16_RESET     16'h0000
`define IFR_POL_RESET       5'h00
`define IFR_IRQ_RESET       3'h0

`define IFR_RESP_OKAY       2'b00
`define IFR_RESP_SLVERR     2'b10

`endif

// ===== irq_flags_pkg.sv
// Purpose: Types shared by the interrupt flag block
// Assumes: Nothing beyond the register header
// Notes:   Bus state machines use Gray codes along the usual path
package irq_flags_pkg;

  typedef enum logic [2:0] {
    W_IDLE     = 3'b000,
    W_GOT_ADDR = 3'b001,
    W_EXEC     = 3'b011,
    W_RESP     = 3'b010,
    W_GOT_DATA = 3'b100
  } wr_state_t;

  typedef enum logic {
    R_IDLE = 1'b0,
    R_DATA = 1'b1
  } rd_state_t;

  typedef logic [15:0] reg16_t;

endpackage

// ===== edge_event_detect.sv
// Purpose: One external interrupt input turned into a one-cycle edge pulse
// Assumes: level_in is synchronous to aclk
// Notes:   No edge is reported in the first cycle after reset, before a sample exists
`timescale 1ns/10ps
module edge_event_detect (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level_in,
  input  wire logic falling_sel,
  output logic      edge_pulse
);

  logic prev_q;
  logic armed_q;
  logic hit;

  // Polarity is applied to stored and current samples, so changing it makes no false edge
  assign hit = armed_q & (falling_sel ? (prev_q & ~level_in) : (~prev_q & level_in));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q     <= 1'b0;
      armed_q    <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_q     <= level_in;
      armed_q    <= 1'b1;
      edge_pulse <= hit;
    end
  end

endmodule

// ===== interrupt_flag_and_control_regs.sv
// Purpose: Interrupt control register and three pending-flag registers behind AXI4-Lite
// Assumes: Peripheral requests are one-cycle pulses synchronous to aclk
// Notes:   Flags also raise a summary interrupt through a sticky status and mask pair
// Notes on behaviour
// - Control bit 15 selects the alternate vector table when set.
// - Control bit 14 is read-only, high while interrupt disable is active.
// - Control bits 4..0 pick edge polarity: 1 falling, 0 rising.
// - Control bits 13..5 read zero and ignore writes.
// - All implemented bits reset to zero.
// - Flag bits read 1 after a request, and are software readable and writable.
// - Flags 0 bit 15 reads zero; bits 14..8 map DMA1 to timer 3.
// - Flags 0 bits 7..0 map timer 2 down to external interrupt 0.
// - Flags 1 bits 15..8 map UART2 transmit down to DMA channel 2.
// - Flags 1 bits 7..3 capture/converter/ext1/change; bit 2 zero; bits 1..0 I2C1.
// - Flags 2 bits 15,14 timer 6, DMA4; bit 13 zero; 12..8 compares, capture 6.
// - Flags 2 bits 7..3 map captures 5..3, DMA3 and CAN1 event.
// - Flags 2 bits 2..0 map CAN1 receive, SPI2 event and SPI2 error.
`timescale 1ns/10ps
`include "irq_flags_regs.svh"
module interrupt_flag_and_control_regs
  import irq_flags_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [`IFR_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [`IFR_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [15:0]                 src_req0,
  input  wire logic [15:0]                 src_req1,
  input  wire logic [15:0]                 src_req2,
  input  wire logic [`IFR_EXT_COUNT-1:0]   ext_int_in,
  input  wire logic                        irq_disable_in,
  output logic [`IFR_EXT_COUNT-1:0]        ext_edge_event,
  output logic                             alt_vector_select,
  output logic [15:0]                      flags0,
  output logic [15:0]                      flags1,
  output logic [15:0]                      flags2,
  output logic                             irq
);

  // Write channel state
  wr_state_t                   wr_state_q;
  wr_state_t                   wr_state_d;
  logic [`IFR_ADDR_W-1:0]      awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        aw_fire;
  logic                        w_fire;
  logic                        b_fire;

  // Read channel state
  rd_state_t                   rd_state_q;
  rd_state_t                   rd_state_d;
  logic                        ar_fire;
  logic                        r_fire;
  logic [31:0]                 rd_word;
  logic                        rd_err;

  // Register contents
  logic                        irq_disable_active_q;
  logic [`IFR_EXT_COUNT-1:0]   edge_polarity_q;
  reg16_t                      flags0_q;
  reg16_t                      flags1_q;
  reg16_t                      flags2_q;
  logic [`IFR_IRQ_W-1:0]       irq_status_q;
  logic [`IFR_IRQ_W-1:0]       irq_mask_q;

  // Write decode
  logic [`IFR_ADDR_W-1:0]      wr_addr;
  logic                        wr_exec;
  logic                        hit_ctrl;
  logic                        hit_flags0;
  logic                        hit_flags1;
  logic                        hit_flags2;
  logic                        hit_status;
  logic                        hit_mask;
  logic                        wr_err;
  reg16_t                      wr_half;

  // Hardware set vectors
  reg16_t                      set0;
  reg16_t                      set1;
  reg16_t                      set2;
  logic [`IFR_IRQ_W-1:0]       irq_event;
  logic [`IFR_IRQ_W-1:0]       irq_clear;

  function automatic reg16_t merge_lanes(
    input reg16_t     cur,
    input logic [15:0] wd,
    input logic [1:0]  strb
  );
    reg16_t res;
    res = cur;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic reg16_t flag_next(
    input reg16_t      cur,
    input reg16_t      set,
    input reg16_t      impl,
    input logic        hit,
    input logic [15:0] wd,
    input logic [1:0]  strb
  );
    reg16_t base;
    base = cur;
    if (hit) begin
      base = merge_lanes(cur, wd, strb);
    end
    return (base | set) & impl;
  endfunction

  // External edge detectors, one per input
  genvar gi;
  generate
    for (gi = 0; gi < `IFR_EXT_COUNT; gi++) begin : g_ext
      edge_event_detect u_edge (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .level_in    (ext_int_in[gi]),
        .falling_sel (edge_polarity_q[gi]),
        .edge_pulse  (ext_edge_event[gi])
      );
    end
  endgenerate

  // Route source pulses and external edges 0..2 onto the documented flag positions; edges 3 and 4 set no flag
  always_comb begin
    set0                = src_req0 & `IFR_FLAGS0_IMPL;
    set0[`IFR_EXT0_BIT] = ext_edge_event[0];
    set1                = src_req1 & `IFR_FLAGS1_IMPL;
    set1[`IFR_EXT1_BIT] = ext_edge_event[1];
    set1[`IFR_EXT2_BIT] = ext_edge_event[2];
    set2                = src_req2 & `IFR_FLAGS2_IMPL;
  end

  // AXI handshakes
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign b_fire  = s_axi_bvalid & s_axi_bready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign r_fire  = s_axi_rvalid & s_axi_rready;

  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      W_IDLE: begin
        if (aw_fire && w_fire) begin
          wr_state_d = W_EXEC;
        end else if (aw_fire) begin
          wr_state_d = W_GOT_ADDR;
        end else if (w_fire) begin
          wr_state_d = W_GOT_DATA;
        end
      end
      W_GOT_ADDR: begin
        if (w_fire) begin
          wr_state_d = W_EXEC;
        end
      end
      W_GOT_DATA: begin
        if (aw_fire) begin
          wr_state_d = W_EXEC;
        end
      end
      W_EXEC: begin
        wr_state_d = W_RESP;
      end
      W_RESP: begin
        if (b_fire) begin
          wr_state_d = W_IDLE;
        end
      end
      default: begin
        wr_state_d = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q    <= W_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      wr_state_q    <= wr_state_d;
      s_axi_awready <= (wr_state_d == W_IDLE) || (wr_state_d == W_GOT_DATA);
      s_axi_wready  <= (wr_state_d == W_IDLE) || (wr_state_d == W_GOT_ADDR);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write decode on the captured word address
  assign wr_exec    = (wr_state_q == W_EXEC);
  assign wr_addr    = {awaddr_q[`IFR_ADDR_W-1:2], 2'b00};
  assign wr_half    = wdata_q[15:0];
  assign hit_ctrl   = wr_exec && (wr_addr == `IFR_CTRL_OFS);
  assign hit_flags0 = wr_exec && (wr_addr == `IFR_FLAGS0_OFS);
  assign hit_flags1 = wr_exec && (wr_addr == `IFR_FLAGS1_OFS);
  assign hit_flags2 = wr_exec && (wr_addr == `IFR_FLAGS2_OFS);
  assign hit_status = wr_exec && (wr_addr == `IFR_IRQ_STATUS_OFS);
  assign hit_mask   = wr_exec && (wr_addr == `IFR_IRQ_MASK_OFS);
  assign wr_err     = wr_exec && !(hit_ctrl || hit_flags0 || hit_flags1 || hit_flags2
                                   || hit_status || hit_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IFR_RESP_OKAY;
    end else if (wr_exec) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `IFR_RESP_SLVERR : `IFR_RESP_OKAY;
    end else if (b_fire) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; bits 13..5 have no storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_vector_select <= 1'b0;
      edge_polarity_q   <= `IFR_POL_RESET;
    end else if (hit_ctrl) begin
      if (wstrb_q[1]) begin
        alt_vector_select <= wdata_q[`IFR_CTRL_ALT_BIT];
      end
      if (wstrb_q[0]) begin
        edge_polarity_q <= wdata_q[`IFR_CTRL_POL_MSB:0];
      end
    end
  end

  // Interrupt disable status follows the core, software cannot write it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_disable_active_q <= 1'b0;
    end else begin
      irq_disable_active_q <= irq_disable_in;
    end
  end

  // Pending flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags0_q <= `IFR_REG16_RESET;
      flags1_q <= `IFR_REG16_RESET;
      flags2_q <= `IFR_REG16_RESET;
    end else begin
      flags0_q <= flag_next(flags0_q, set0, `IFR_FLAGS0_IMPL, hit_flags0, wr_half,
                            wstrb_q[1:0]);
      flags1_q <= flag_next(flags1_q, set1, `IFR_FLAGS1_IMPL, hit_flags1, wr_half,
                            wstrb_q[1:0]);
      flags2_q <= flag_next(flags2_q, set2, `IFR_FLAGS2_IMPL, hit_flags2, wr_half,
                            wstrb_q[1:0]);
    end
  end

  assign flags0 = flags0_q;
  assign flags1 = flags1_q;
  assign flags2 = flags2_q;

  // Summary interrupt: a status bit per flag register records a newly raised flag
  assign irq_event = {|(set2 & ~flags2_q), |(set1 & ~flags1_q), |(set0 & ~flags0_q)};
  assign irq_clear = (hit_status && wstrb_q[0]) ? wdata_q[`IFR_IRQ_W-1:0] : `IFR_IRQ_RESET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= `IFR_IRQ_RESET;
    end else begin
      // A new event wins over a write-one clear in the same cycle
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= `IFR_IRQ_RESET;
    end else if (hit_mask && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[`IFR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read data mux; reads have no side effects
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    case ({s_axi_araddr[`IFR_ADDR_W-1:2], 2'b00})
      `IFR_CTRL_OFS: begin
        rd_word[`IFR_CTRL_ALT_BIT]     = alt_vector_select;
        rd_word[`IFR_CTRL_DIS_BIT]     = irq_disable_active_q;
        rd_word[`IFR_CTRL_POL_MSB:0]   = edge_polarity_q;
      end
      `IFR_FLAGS0_OFS: begin
        rd_word[15:0] = flags0_q;
      end
      `IFR_FLAGS1_OFS: begin
        rd_word[15:0] = flags1_q;
      end
      `IFR_FLAGS2_OFS: begin
        rd_word[15:0] = flags2_q;
      end
      `IFR_IRQ_STATUS_OFS: begin
        rd_word[`IFR_IRQ_W-1:0] = irq_status_q;
      end
      `IFR_IRQ_MASK_OFS: begin
        rd_word[`IFR_IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_comb begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      R_IDLE: begin
        if (ar_fire) begin
          rd_state_d = R_DATA;
        end
      end
      R_DATA: begin
        if (r_fire) begin
          rd_state_d = R_IDLE;
        end
      end
      default: begin
        rd_state_d = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q    <= R_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IFR_RESP_OKAY;
    end else begin
      rd_state_q    <= rd_state_d;
      s_axi_arready <= (rd_state_d == R_IDLE);
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_err ? `IFR_RESP_SLVERR : `IFR_RESP_OKAY;
      end else if (r_fire) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== irq_flags_asserts.sv
// Purpose: Port-level checks of the interrupt flag and control block
// Assumes: Single aclk domain, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
`include "irq_flags_regs.svh"
module irq_flags_asserts (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic [15:0]               src_req0,
  input wire logic [15:0]               src_req1,
  input wire logic [15:0]               src_req2,
  input wire logic [`IFR_EXT_COUNT-1:0] ext_int_in,
  input wire logic [`IFR_EXT_COUNT-1:0] ext_edge_event,
  input wire logic [15:0]               flags0,
  input wire logic [15:0]               flags1,
  input wire logic [15:0]               flags2
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_F0_ZERO: assert property (flags0[15] == 1'b0)
    else $error("flags0 bit 15 not zero");
  AST_F1_ZERO: assert property (flags1[2] == 1'b0)
    else $error("flags1 bit 2 not zero");
  AST_F2_ZERO: assert property (flags2[13] == 1'b0)
    else $error("flags2 bit 13 not zero");
  AST_SET0: assert property (|(src_req0 & 16'h7ffe) |=>
    (flags0 & $past(src_req0) & 16'h7ffe) == ($past(src_req0) & 16'h7ffe))
    else $error("flags0 missed a request");
  AST_SET1: assert property (|(src_req1 & 16'hdfeb) |=>
    (flags1 & $past(src_req1) & 16'hdfeb) == ($past(src_req1) & 16'hdfeb))
    else $error("flags1 missed a request");
  AST_SET2: assert property (|(src_req2 & 16'hdfff) |=>
    (flags2 & $past(src_req2) & 16'hdfff) == ($past(src_req2) & 16'hdfff))
    else $error("flags2 missed a request");
  AST_STICKY: assert property (|(($past(flags0) & ~flags0) | ($past(flags1) & ~flags1) |
    ($past(flags2) & ~flags2)) |-> $rose(s_axi_bvalid))
    else $error("flag cleared without a write");
  AST_EXT_FLAG: assert property (ext_edge_event[2:0] != 3'h0 |=>
    ({flags1[13], flags1[4], flags0[0]} & $past(ext_edge_event[2:0])) ==
    $past(ext_edge_event[2:0]))
    else $error("external edge not flagged");
  AST_EDGE_CAUSE: assert property (ext_edge_event != 5'h00 |->
    (ext_edge_event & ~(($past(ext_int_in) ^ $past(ext_int_in, 2)) |
    ($past(ext_int_in, 2) ^ $past(ext_int_in, 3)))) == 5'h00)
    else $error("edge event without input change");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind interrupt_flag_and_control_regs irq_flags_asserts u_irq_flags_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .src_req0(src_req0), .src_req1(src_req1),
  .src_req2(src_req2), .ext_int_in(ext_int_in), .ext_edge_event(ext_edge_event),
  .flags0(flags0), .flags1(flags1), .flags2(flags2)
);

// ===== periph_model.sv
// Purpose: Peripheral and pin model driving request pulses and external levels
// Assumes: Commands from the bench change just after a rising edge
// Notes:   An armed pulse fires on the write handshake so it meets the flag update edge
`timescale 1ns/10ps
module periph_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        fire,
  input  wire logic        arm,
  input  wire logic        wr_take,
  input  wire logic [1:0]  sel,
  input  wire logic [15:0] bits,
  input  wire logic [4:0]  ext_lvl,
  input  wire logic        dis_lvl,
  output logic [15:0]      src_req0,
  output logic [15:0]      src_req1,
  output logic [15:0]      src_req2,
  output logic [4:0]       ext_int_in,
  output logic             irq_disable_in
);
  logic go;
  assign go = fire | (arm & wr_take);
  // One-cycle request pulse per command
  always_ff @(posedge aclk) begin
    src_req0 <= (aresetn && go && sel == 2'h0) ? bits : 16'h0000;
    src_req1 <= (aresetn && go && sel == 2'h1) ? bits : 16'h0000;
    src_req2 <= (aresetn && go && sel == 2'h2) ? bits : 16'h0000;
  end
  always_ff @(posedge aclk) begin
    ext_int_in     <= ext_lvl;
    irq_disable_in <= dis_lvl;
  end
endmodule

// ===== test_interrupt_flag_and_control_regs.sv
// Purpose: Register-level test of the interrupt flag and control block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   Peripheral pulses come from the partner model
`timescale 1ns/10ps
`include "irq_flags_regs.svh"
module test_interrupt_flag_and_control_regs;
  localparam logic [1:0] OK = `IFR_RESP_OKAY;
  localparam logic [1:0] ER = `IFR_RESP_SLVERR;
  localparam logic [7:0] FA [3] = '{8'h04, 8'h08, 8'h0c};
  localparam logic [15:0] IM [3] = '{16'h7fff, 16'hfffb, 16'hdfff};
  localparam logic [15:0] HW [3] = '{16'h7ffe, 16'hdfeb, 16'hdfff};
  localparam logic [7:0] EA [3] = '{8'h04, 8'h08, 8'h08};
  localparam logic [15:0] EB [3] = '{16'h0001, 16'h0010, 16'h2000};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irq_disable_in, irq, alt_vector_select, fire, arm, dis_lvl;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sel;
  logic [15:0] src_req0, src_req1, src_req2, flags0, flags1, flags2, bits;
  logic [4:0]  ext_int_in, ext_edge_event, ext_lvl;
  int          bad_count, samples_checked;
  logic [3:0]  s_axi_wstrb;
  int          edge_cnt [5];
  wire logic   wr_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;

  interrupt_flag_and_control_regs u_interrupt_flag_and_control_regs (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_req0,
    .src_req1, .src_req2, .ext_int_in, .irq_disable_in, .ext_edge_event,
    .alt_vector_select, .flags0, .flags1, .flags2, .irq);
  periph_model u_periph_model (.aclk, .aresetn, .fire, .arm, .wr_take, .sel, .bits,
    .ext_lvl, .dis_lvl, .src_req0, .src_req1, .src_req2, .ext_int_in, .irq_disable_in);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counts edge pulses per input, since each stands for one cycle only
  always @(posedge aclk) begin
    for (int k = 0; k < 5; k++) begin
      if (ext_edge_event[k] === 1'b1) begin
        edge_cnt[k] <= edge_cnt[k] + 1;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic pulse(input logic [1:0] r, input logic [15:0] b);
    @(posedge aclk);
    sel <= r;
    bits <= b;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    tick(3);
  endtask
  task automatic ext_step(input int i, input logic [31:0] pol, input logic lvl, input logic hit);
    int n0;
    wr(8'h00, pol, OK);
    n0 = edge_cnt[i];
    ext_lvl[i] <= lvl;
    tick(4);
    chk("ext_edge_event", edge_cnt[i] - n0, {31'h0, hit});
    if (i < 3) begin
      rc(EA[i], hit ? {16'h0, EB[i]} : 32'h0, OK);
      wr(EA[i], 32'h0, OK);
    end
  endtask
  task automatic irq_is(input logic e);
    tick(2);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, arm, dis_lvl, sel, bits, ext_lvl} = '0;
    s_axi_wstrb = 4'hf;
    tick(8);
    aresetn <= 1'b1;
    rc(8'h00, 32'h0, OK);
    for (int i = 0; i < 3; i++) rc(FA[i], 32'h0, OK);
    chk("alt_vector_select", {31'h0, alt_vector_select}, 32'h0);
    wr(8'h00, 32'hffffffff, OK);
    rc(8'h00, 32'h801f, OK);
    chk("alt_vector_select", {31'h0, alt_vector_select}, 32'h1);
    dis_lvl <= 1'b1;
    tick(4);
    wr(8'h00, 32'h0, OK);
    rc(8'h00, 32'h4000, OK);
    dis_lvl <= 1'b0;
    tick(4);
    rc(8'h00, 32'h0, OK);
    for (int i = 0; i < 3; i++) begin
      wr(FA[i], 32'hffffffff, OK);
      rc(FA[i], {16'h0, IM[i]}, OK);
      wr(FA[i], 32'h0, OK);
      rc(FA[i], 32'h0, OK);
    end
    rc(8'h10, 32'h0, OK);
    for (int i = 0; i < 5; i++) begin
      ext_step(i, 32'h1f, 1'b1, 1'b0);
      ext_step(i, 32'h00, 1'b0, 1'b0);
      ext_step(i, 32'h00, 1'b1, 1'b1);
      ext_step(i, 32'h1f, 1'b0, 1'b1);
    end
    wr(8'h10, 32'h7, OK);
    rc(8'h10, 32'h0, OK);
    for (int i = 0; i < 3; i++) begin
      pulse(i[1:0], 16'hffff);
      rc(FA[i], {16'h0, HW[i]}, OK);
    end
    rc(8'h10, 32'h7, OK);
    irq_is(1'b0);
    wr(8'h14, 32'h1, OK);
    irq_is(1'b1);
    wr(8'h10, 32'h1, OK);
    irq_is(1'b0);
    rc(8'h10, 32'h6, OK);
    wr(8'h14, 32'h6, OK);
    irq_is(1'b1);
    wr(8'h10, 32'h6, OK);
    irq_is(1'b0);
    wr(FA[0], 32'h0100, OK);
    sel <= 2'h0;
    bits <= 16'h0300;
    arm <= 1'b1;
    wr(FA[0], 32'h0, OK);
    arm <= 1'b0;
    rc(FA[0], 32'h0300, OK);
    wr(8'h20, 32'hffffffff, ER);
    rc(8'h20, 32'h0, ER);
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'hffffffff, OK);
    rc(8'h00, 32'h001f, OK);
    s_axi_wstrb <= 4'h2;
    wr(8'h00, 32'h00008000, OK);
    rc(8'h00, 32'h801f, OK);
    s_axi_wstrb <= 4'hf;
    wr(8'h00, 32'h8001, OK);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    rc(FA[0], 32'h0, OK);
    rc(8'h00, 32'h0, OK);
    rc(8'h14, 32'h0, OK);
    print_verdict;
  end
endmodule
